// >>> dv/lmc_lin_mode_ctrl_chk.sv
// port checker for the transceiver mode control block
module lmc_chk (
	input wire clock,
	input wire nrst,
	input wire [2:0] chipOperatingState,
	input wire modeWrite,
	input wire [1:0] modeWriteData,
	input wire modeWriteReject,
	input wire [1:0] linModeField,
	input wire linRxOutput,
	input wire busDriveLow,
	input wire linFaultFlag,
	input wire wakeEvent
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	property p_rst; disable iff (1'b0)
		!nrst |=> linModeField == 2'h0 && !busDriveLow; endproperty
	a_rst: assert property (p_rst) else $error("not off after reset");
	property p_off; modeWrite && modeWriteData == 2'h0 |-> !modeWriteReject
		##1 (linModeField == 2'h0 || chipOperatingState == 3'h4); endproperty
	a_off: assert property (p_off) else $error("off refused");
	property p_rej; modeWrite && modeWriteData[1] &&
		chipOperatingState > 3'h1 |-> modeWriteReject; endproperty
	a_rej: assert property (p_rej) else $error("write not refused");
	property p_nodrv; linModeField != 2'h3 &&
		$past(linModeField) != 2'h3 |-> !busDriveLow; endproperty
	a_nodrv: assert property (p_nodrv) else $error("drive off mode");
	property p_flt; $rose(linFaultFlag) |-> ##[0:1] !busDriveLow; endproperty
	a_flt: assert property (p_flt) else $error("drive after trip");
	property p_wk; wakeEvent |-> linModeField == 2'h1 ##1 !wakeEvent; endproperty
	a_wk: assert property (p_wk) else $error("wake field");
	property p_rxl; wakeEvent |-> ##[0:1] !linRxOutput; endproperty
	a_rxl: assert property (p_rxl) else $error("receive not low");
	property p_offw; linModeField == 2'h0 &&
		$past(linModeField) == 2'h0 |-> !wakeEvent; endproperty
	a_offw: assert property (p_offw) else $error("wake while off");
	c_rej: cover property (modeWriteReject);
	c_wk: cover property (wakeEvent);
	c_flt: cover property ($rose(linFaultFlag));
endmodule // lmc_chk
bind lmc_lin_mode_ctrl lmc_chk u_lmc_chk (.clock(clock), .nrst(nrst),
	.chipOperatingState(chipOperatingState), .modeWrite(modeWrite),
	.modeWriteData(modeWriteData), .modeWriteReject(modeWriteReject),
	.linModeField(linModeField), .linRxOutput(linRxOutput),
	.busDriveLow(busDriveLow), .linFaultFlag(linFaultFlag),
	.wakeEvent(wakeEvent));

// >>> dv/lmc_mcu_model.sv
// microcontroller side: transmit pin and stalling receive stream
module lmc_mcu_model (
	input wire logic clock,
	input wire logic txLow,
	output logic linTxInput = 1'b1,
	output logic rxReady = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(negedge clock) begin
		linTxInput <= !txLow;
		rxReady <= ($urandom % 3) != 0;
	end
endmodule // lmc_mcu_model

// >>> dv/test_lmc_lin_mode_ctrl.sv
// bench for the transceiver mode control block
module test_lmc_lin_mode_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0, nrst = 1'b0, modeWrite = 1'b0, faultClear = 1'b0;
	logic txLow = 1'b0, extDom = 1'b0, chk = 1'b0, wd = 1'b0, rj, r = 1'b0;
	logic [2:0] chipOperatingState = 3'h0;
	logic [1:0] modeWriteData = 2'h0, m = 2'h0;
	wire modeWriteReject, linTxInput, linRxOutput, busDriveLow, linFaultFlag;
	wire wakeEvent, rxValid, rxReady, rxData;
	wire [1:0] linModeField;
	wire busLevelIn = !(busDriveLow | extDom);
	int num_errors = 0, n_checks = 0;
	logic [2:0] wq[$];
	logic sq[$];
	always #50 clock = !clock;
	lmc_lin_mode_ctrl #(.EN_CYCLES(4), .TXD_TO_CYCLES(20), .WAKE_CYCLES(5))
	u_lmc_lin_mode_ctrl (.clock(clock), .nrst(nrst),
		.chipOperatingState(chipOperatingState), .modeWrite(modeWrite),
		.modeWriteData(modeWriteData), .modeWriteReject(modeWriteReject),
		.linModeField(linModeField), .linTxInput(linTxInput),
		.linRxOutput(linRxOutput), .busLevelIn(busLevelIn),
		.busDriveLow(busDriveLow), .linFaultFlag(linFaultFlag),
		.faultClear(faultClear), .wakeEvent(wakeEvent), .rxValid(rxValid),
		.rxReady(rxReady), .rxData(rxData));
	lmc_mcu_model u_lmc_mcu_model (.clock(clock), .txLow(txLow),
		.linTxInput(linTxInput), .rxReady(rxReady));
	task automatic cmp(input logic [2:0] s, input logic [2:0] e);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %0t %h %h", $time, s, e);
		end
	endtask
	task automatic finish_test;
		if (num_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wr(input logic [2:0] st, input logic [1:0] d);
		@(negedge clock);
		chipOperatingState = st;
		modeWrite = 1'b1;
		modeWriteData = d;
		rj = d[1] && st > 3'h1;
		if (!rj) m = d;
		wq.push_back({rj, m});
		@(negedge clock);
		modeWrite = 1'b0;
	endtask
	function automatic logic sig(input int k);
		return k == 0 ? busDriveLow : k == 1 ? linFaultFlag :
			k == 2 ? wakeEvent : k == 3 ? linRxOutput : rxValid;
	endfunction
	task automatic wt(input int k, input logic v);
		int i;
		n_checks++;
		for (i = 0; i < 40 && sig(k) !== v; i++) @(negedge clock);
		if (i == 40) begin
			cmp({2'h0, sig(k)}, {2'h0, v});
			finish_test();
		end
	endtask
	always @(posedge clock) begin
		if (wd) cmp({r, linModeField}, wq.pop_front());
		if (chk && rxValid && rxReady)
			cmp({2'h0, rxData}, {2'h0, sq.pop_front()});
		wd <= modeWrite;
		r <= modeWriteReject;
	end
	initial begin
		void'($urandom(32'hDE46));
		repeat (12) @(negedge clock);
		nrst = 1'b1;
		cmp({busDriveLow, linModeField}, 3'h0);
		for (int s = 0; s < 4; s++)
			for (int d = 0; d < 4; d++)
				wr(3'(s), 2'(d));
		txLow = 1'b1;
		wr(3'h0, 2'h3);
		repeat (12) @(negedge clock);
		cmp({2'h0, busDriveLow}, 3'h0);
		txLow = 1'b0;
		repeat (4) @(negedge clock);
		txLow = 1'b1;
		wt(0, 1'b1);
		wt(3, 1'b0);
		wt(1, 1'b1);
		txLow = 1'b0;
		faultClear = 1'b1;
		@(negedge clock);
		faultClear = 1'b0;
		wt(1, 1'b0);
		wr(3'h0, 2'h0);
		repeat (10) @(negedge clock);
		wt(4, 1'b0);
		chk = 1'b1;
		wr(3'h1, 2'h2);
		repeat (6) begin
			extDom = !extDom;
			sq.push_back(!extDom);
			repeat (12) @(negedge clock);
		end
		cmp(3'(sq.size()), 3'h0);
		chk = 1'b0;
		for (int w = 0; w < 2; w++) begin
			wr(3'h0, 2'(w));
			extDom = 1'b1;
			repeat (8) @(negedge clock);
			extDom = 1'b0;
			repeat (4) @(negedge clock);
		end
		wt(2, 1'b1);
		@(negedge clock);
		cmp({linRxOutput, linModeField}, 3'h1);
		wr(3'h0, 2'h3);
		wt(3, 1'b1);
		finish_test();
	end
endmodule // test_lmc_lin_mode_ctrl

// >>> hdl/lmc_buf2.v
// two-entry valid/ready buffer
module lmc_buf2 #(
	parameter WIDTH = 8
) (
	input wire clock,
	input wire nrst,
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] mem_r [0:1];
	reg wrPtr_r;
	reg rdPtr_r;
	reg [1:0] count_r;
	wire push;
	wire pop;
	assign inReady = (count_r != 2'h2);
	assign outValid = (count_r != 2'h0);
	assign outData = mem_r[rdPtr_r];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	always @(posedge clock) begin
		if (!nrst) begin
			wrPtr_r <= 1'b0;
			rdPtr_r <= 1'b0;
			count_r <= 2'h0;
			mem_r[0] <= {WIDTH{1'b0}};
			mem_r[1] <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				mem_r[wrPtr_r] <= inData;
				wrPtr_r <= ~wrPtr_r;
			end
			if (pop)
				rdPtr_r <= ~rdPtr_r;
			if (push && !pop)
				count_r <= count_r + 2'h1;
			else if (pop && !push)
				count_r <= count_r - 2'h1;
		end
	end
endmodule // lmc_buf2

// >>> hdl/lmc_lin_mode_ctrl.v
// transceiver mode control: mode select, enabling delay, time-out, wake
// Notes on behaviour
// - after reset the mode is off and the bus is not driven.
// - off may be selected whatever the chip operating state; in fail-safe the mode reverts to wake-capable a cycle later.
// - while off, bus wake activity is ignored and gives no wake.
// - the mode is chosen by writing the mode field; each code is one mode.
// - the host enables normal mode by a write in chip normal state.
// - normal mode is accepted only in chip normal or stop state.
// - in normal mode the bus driver follows the transmit input.
// - in receiving modes the bus level appears on the receive output.
// - a low seen during the delay must go high; only the next low is sent.
// - in receive-only mode the driver is off but reception goes on.
// - receive-only is accepted only in chip normal or stop state.
// - after a bus wake the mode field still reads wake-capable.
// - after a bus wake receive stays low until the mode changes.
// - transmit dominant past the time-out drops the driver, sets fault.
`include "lmc_regs.vh"
module lmc_lin_mode_ctrl #(
	parameter EN_CYCLES = (`LMC_EN_TIME_US * (`LMC_CLK_HZ / 1000000)),
	parameter TXD_TO_CYCLES =
		(`LMC_TXD_TO_US * (`LMC_CLK_HZ / 1000000)),
	parameter WAKE_CYCLES = (`LMC_WAKE_FILT_US * (`LMC_CLK_HZ / 1000000)),
	parameter CNT_W = 18
) (
	input wire clock,
	input wire nrst,
	input wire [2:0] chipOperatingState,
	input wire modeWrite,
	input wire [1:0] modeWriteData,
	output wire modeWriteReject,
	output reg [1:0] linModeField,
	input wire linTxInput,
	output reg linRxOutput,
	input wire busLevelIn,
	output reg busDriveLow,
	output reg linFaultFlag,
	input wire faultClear,
	output reg wakeEvent,
	output wire rxValid,
	input wire rxReady,
	output wire rxData
);
	localparam TX_OFF = 3'h0;
	localparam TX_WAIT = 3'h1;
	localparam TX_HOLD = 3'h2;
	localparam TX_LIVE = 3'h3;
	localparam TX_TRIP = 3'h4;
	wire [1:0] pinRaw;
	wire [1:0] pinLvl;
	wire txLvl_r;
	wire busLvl_r;
	reg [2:0] txState_r;
	reg [2:0] txState_nxt;
	reg [CNT_W-1:0] txCnt_r;
	reg [CNT_W-1:0] txCnt_nxt;
	wire enterNormal;
	wire cntHitEn;
	wire cntHitTo;
	reg wkFall_r;
	reg pend_r;
	reg pendData_r;
	wire rxChange;
	wire bufInValid;
	wire bufInData;
	reg [CNT_W-1:0] wkCnt_r;
	reg wkLong_r;
	reg woken_r;
	reg busPrev_r;
	wire allowed;
	wire accept;
	wire modeChange;
	wire txActive;
	wire bufInReady;

	function stateAllowsActive;
		input [2:0] st;
		begin
			stateAllowsActive = (st == `LMC_CHIP_NORMAL) ||
				(st == `LMC_CHIP_STOP);
		end
	endfunction

	function isRxMode;
		input [1:0] md;
		begin
			isRxMode = (md == `LMC_MODE_NORMAL) ||
				(md == `LMC_MODE_RXONLY);
		end
	endfunction

	// wake-capable also allowed in sleep, restart and fail-safe; off always
	assign allowed =
		(modeWriteData == `LMC_MODE_OFF) ||
		(modeWriteData == `LMC_MODE_WAKE) ||
		stateAllowsActive(chipOperatingState);
	assign accept = modeWrite && allowed;
	assign modeWriteReject = modeWrite && !allowed;
	assign modeChange = accept && (modeWriteData != linModeField);
	assign txActive = (txState_r == TX_LIVE);
	assign enterNormal = modeChange &&
		(modeWriteData == `LMC_MODE_NORMAL);
	assign cntHitEn = (txCnt_r == EN_CYCLES[CNT_W-1:0] - 1'b1);
	assign cntHitTo = (txCnt_r == TXD_TO_CYCLES[CNT_W-1:0] - 1'b1);
	assign rxChange = isRxMode(linModeField) && (busLvl_r != busPrev_r);
	assign bufInValid = pend_r || rxChange;
	assign bufInData = pend_r ? pendData_r : busLvl_r;

	// three-stage pin synchronisers, change taken when stages 2 and 3 agree
	assign pinRaw = {busLevelIn, linTxInput};
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_pinSync
			reg [2:0] sync_r;
			reg lvl_r;
			always @(posedge clock) begin
				if (!nrst) begin
					sync_r <= {3{1'b1}};
					lvl_r <= 1'b1;
				end else begin
					sync_r <= {sync_r[1:0], pinRaw[gi]};
					if (sync_r[1] == sync_r[2])
						lvl_r <= sync_r[2];
				end
			end
			assign pinLvl[gi] = lvl_r;
		end
	endgenerate
	assign txLvl_r = pinLvl[0];
	assign busLvl_r = pinLvl[1];

	always @(posedge clock) begin
		if (!nrst) begin
			linModeField <= `LMC_MODE_OFF;
		end else if (accept) begin
			linModeField <= modeWriteData;
		end else if (woken_r &&
			(chipOperatingState == `LMC_CHIP_FAILSAFE)) begin
			linModeField <= `LMC_MODE_WAKE;
		end else if (chipOperatingState == `LMC_CHIP_FAILSAFE) begin
			linModeField <= `LMC_MODE_WAKE;
		end
	end

	// transmit path: enabling delay, wait for recessive, live, time-out
	always @* begin
		txState_nxt = txState_r;
		txCnt_nxt = txCnt_r;
		if (linModeField != `LMC_MODE_NORMAL || enterNormal) begin
			txState_nxt = TX_OFF;
			txCnt_nxt = {CNT_W{1'b0}};
		end else begin
			case (txState_r)
			TX_OFF: begin
				txState_nxt = TX_WAIT;
				txCnt_nxt = {CNT_W{1'b0}};
			end
			TX_WAIT: begin
				if (cntHitEn) begin
					txState_nxt = TX_HOLD;
					txCnt_nxt = {CNT_W{1'b0}};
				end else begin
					txCnt_nxt = txCnt_r + 1'b1;
				end
			end
			TX_HOLD: begin
				if (txLvl_r)
					txState_nxt = TX_LIVE;
			end
			TX_LIVE: begin
				if (txLvl_r) begin
					txCnt_nxt = {CNT_W{1'b0}};
				end else if (cntHitTo) begin
					txState_nxt = TX_TRIP;
					txCnt_nxt = {CNT_W{1'b0}};
				end else begin
					txCnt_nxt = txCnt_r + 1'b1;
				end
			end
			TX_TRIP: begin
				// driver returns once dominant ends
				if (txLvl_r)
					txState_nxt = TX_LIVE;
			end
			default: begin
				txState_nxt = TX_OFF;
			end
			endcase
		end
	end

	always @(posedge clock) begin
		if (!nrst) begin
			txState_r <= TX_OFF;
			txCnt_r <= {CNT_W{1'b0}};
		end else begin
			txState_r <= txState_nxt;
			txCnt_r <= txCnt_nxt;
		end
	end

	// sticky fault; a new trip wins over a clear in the same cycle
	always @(posedge clock) begin
		if (!nrst)
			linFaultFlag <= 1'b0;
		else if (txActive && !txLvl_r && cntHitTo)
			linFaultFlag <= 1'b1;
		else if (faultClear)
			linFaultFlag <= 1'b0;
	end

	// bus wake: long dominant followed by return to recessive
	always @(posedge clock) begin
		if (!nrst) begin
			wkCnt_r <= {CNT_W{1'b0}};
			wkLong_r <= 1'b0;
			wkFall_r <= 1'b0;
			woken_r <= 1'b0;
			busPrev_r <= 1'b1;
			wakeEvent <= 1'b0;
		end else begin
			busPrev_r <= busLvl_r;
			wakeEvent <= 1'b0;
			if (linModeField != `LMC_MODE_WAKE || modeChange) begin
				wkCnt_r <= {CNT_W{1'b0}};
				wkLong_r <= 1'b0;
				wkFall_r <= 1'b0;
				woken_r <= 1'b0;
			end else if (!busLvl_r) begin
				// only a dominant phase that began in this mode counts
				if (busPrev_r)
					wkFall_r <= 1'b1;
				if (wkFall_r || busPrev_r) begin
					if (wkCnt_r == WAKE_CYCLES[CNT_W-1:0] - 1'b1)
						wkLong_r <= 1'b1;
					else
						wkCnt_r <= wkCnt_r + 1'b1;
				end
			end else begin
				wkCnt_r <= {CNT_W{1'b0}};
				wkLong_r <= 1'b0;
				wkFall_r <= 1'b0;
				if (!busPrev_r && wkLong_r && !woken_r) begin
					woken_r <= 1'b1;
					wakeEvent <= 1'b1;
				end
			end
		end
	end

	// pin outputs
	always @(posedge clock) begin
		if (!nrst) begin
			busDriveLow <= 1'b0;
			linRxOutput <= 1'b1;
		end else begin
			busDriveLow <= txActive && !txLvl_r;
			if (isRxMode(linModeField))
				linRxOutput <= busLvl_r;
			else if (linModeField == `LMC_MODE_WAKE)
				linRxOutput <= !woken_r;
			else
				linRxOutput <= 1'b1;
		end
	end

	// a change that meets a full buffer waits here instead of being lost
	always @(posedge clock) begin
		if (!nrst) begin
			pend_r <= 1'b0;
			pendData_r <= 1'b1;
		end else if (bufInValid && !bufInReady) begin
			pend_r <= 1'b1;
			pendData_r <= bufInData;
		end else if (pend_r && rxChange) begin
			pendData_r <= busLvl_r;
		end else begin
			pend_r <= 1'b0;
		end
	end

	// received bus levels streamed out; a stall drops nothing up to three words
	lmc_buf2 #(
		.WIDTH(1)
	) u_rxBuf (
		.clock(clock),
		.nrst(nrst),
		.inValid(bufInValid),
		.inReady(bufInReady),
		.inData(bufInData),
		.outValid(rxValid),
		.outReady(rxReady),
		.outData(rxData)
	);
endmodule // lmc_lin_mode_ctrl

// >>> hdl/lmc_regs.vh
// constants for the transceiver mode control block
`ifndef LMC_REGS_VH
`define LMC_REGS_VH
// transceiver mode field encodings
`define LMC_MODE_OFF 2'h0
`define LMC_MODE_WAKE 2'h1
`define LMC_MODE_RXONLY 2'h2
`define LMC_MODE_NORMAL 2'h3
// chip operating states
`define LMC_CHIP_NORMAL 3'h0
`define LMC_CHIP_STOP 3'h1
`define LMC_CHIP_SLEEP 3'h2
`define LMC_CHIP_RESTART 3'h3
`define LMC_CHIP_FAILSAFE 3'h4
// timing
`define LMC_CLK_HZ 10000000
`define LMC_EN_TIME_US 10
`define LMC_TXD_TO_US 12000
`define LMC_WAKE_FILT_US 50
`endif
